// ---- dv/mic_motion_model.sv ----
`timescale 1ns/10ps
module mic_motion_model (
	// Clock
	input  wire logic       core_clk_i,
	// Pins towards the indexer
	output logic            advance_o,
	output logic            direction_o,
	output logic [1:0]      sel_o
);
	initial begin
		advance_o = 1'b0;
		direction_o = 1'b1;
		sel_o = 2'h3;
	end

	// mode and direction set up before the edge
	task automatic step(input logic dir, input logic [1:0] sel);
		@(posedge core_clk_i);
		#2;
		direction_o = dir;
		sel_o = sel;
		repeat (3) @(posedge core_clk_i);
		#2;
		advance_o = 1'b1;
		repeat (4) @(posedge core_clk_i);
		#2;
		advance_o = 1'b0;
		repeat (4) @(posedge core_clk_i);
		#2;
	endtask
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
	logic        core_clk = 1'b0;
	logic        rst_n, drv_off, clr_n, lp_n, ot, uv, adv, dir, br_a, br_b, pump, iclk, home_n, ot_s, uv_l;
	logic [3:0]  oc;
	logic [1:0]  sel, oc_l;
	logic [7:0]  a_t, b_t;
	logic [4:0]  idx;
	logic [31:0] rng = 32'h0000_9316;
	logic [31:0] rnd;
	logic [7:0]  cmag [0:8] = '{8'h64, 8'h62, 8'h5c, 8'h53, 8'h47, 8'h38, 8'h26, 8'h14, 8'h00};
	int          err_count = 0;
	int          check_count = 0;
	int          i;

	always #10 core_clk = ~core_clk;

	mic_indexer_ctrl i_mic_indexer_ctrl (
		.core_clk_i            (core_clk),
		.rst_n_i               (rst_n),
		.advance_pulse_i       (adv),
		.rotation_direction_i  (dir),
		.resolution_sel_hi_i   (sel[1]),
		.resolution_sel_lo_i   (sel[0]),
		.output_drive_off_i    (drv_off),
		.indexer_clear_n_i     (clr_n),
		.low_power_request_n_i (lp_n),
		.overcurrent_trip_i    (oc),
		.overtemp_flag_i       (ot),
		.motor_supply_low_i    (uv),
		.winding_a_target_o    (a_t),
		.winding_b_target_o    (b_t),
		.bridge_a_enable_o     (br_a),
		.bridge_b_enable_o     (br_b),
		.charge_pump_run_o     (pump),
		.internal_clock_run_o  (iclk),
		.home_flag_n_o         (home_n),
		.overcurrent_latch_o   (oc_l),
		.overtemp_shutdown_o   (ot_s),
		.supply_lockout_o      (uv_l)
	);

	mic_motion_model i_mic_motion_model (
		.core_clk_i  (core_clk),
		.advance_o   (adv),
		.direction_o (dir),
		.sel_o       (sel)
	);

	function automatic logic [31:0] xr();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	// Signed cosine for A; B is A shifted back a quadrant
	function automatic logic [7:0] tgt(input logic [4:0] n, input logic b);
		logic [4:0] j;
		logic [7:0] v;
		j = n + (b ? 5'h18 : 5'h00);
		v = j[3] ? cmag[4'h8 - {1'b0, j[2:0]}] : cmag[j[2:0]];
		return (j[4] ^ j[3]) ? -v : v;
	endfunction

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic pos();
		chk("target a", tgt(idx, 1'b0), a_t);
		chk("target b", tgt(idx, 1'b1), b_t);
		chk("home flag", idx != 5'h04, home_n);
	endtask

	task automatic brg(input logic e);
		chk("bridge a", e, br_a);
		chk("bridge b", e, br_b);
	endtask

	task automatic settle();
		repeat (6) @(posedge core_clk);
		#2;
	endtask

	task automatic mv(input logic d, input logic [1:0] s);
		i_mic_motion_model.step(d, s);
		idx = d ? idx + (5'h08 >> s) : idx - (5'h08 >> s);
		pos();
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Watchdog at many times the expected run length
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		complete_run();
	end

	initial begin
		{rst_n, drv_off, ot, uv} = 4'h0;
		{clr_n, lp_n} = 2'h3;
		oc = 4'h0;
		idx = 5'h04;
		repeat (16) @(posedge core_clk);
		#2;
		pos();
		brg(1'b0);
		rst_n = 1'b1;
		settle();
		brg(1'b1);
		chk("pump", 1'b1, pump);
		chk("clock run", 1'b1, iclk);
		$display("test reset done");
		for (i = 0; i < 4; i++) mv(1'b1, 2'h0);
		for (i = 0; i < 5; i++) mv(1'b0, 2'h3);
		mv(1'b1, 2'h3);
		repeat (40) begin
			rnd = xr();
			mv(rnd[31], rnd[2:1]);
		end
		$display("test steps done");
		drv_off = 1'b1;
		settle();
		brg(1'b0);
		mv(1'b1, 2'h1);
		drv_off = 1'b0;
		settle();
		brg(1'b1);
		clr_n = 1'b0;
		settle();
		idx = 5'h04;
		brg(1'b0);
		i_mic_motion_model.step(1'b1, 2'h3);
		pos();
		clr_n = 1'b1;
		settle();
		brg(1'b1);
		mv(1'b1, 2'h2);
		lp_n = 1'b0;
		settle();
		brg(1'b0);
		chk("pump", 1'b0, pump);
		chk("clock run", 1'b0, iclk);
		clr_n = 1'b0;
		i_mic_motion_model.step(1'b1, 2'h3);
		pos();
		clr_n = 1'b1;
		lp_n = 1'b1;
		settle();
		pos();
		brg(1'b1);
		$display("test controls done");
		for (i = 0; i < 4; i++) begin
			mv(1'b1, 2'h3);
			oc[i] = 1'b1;
			settle();
			oc[i] = 1'b0;
			idx = 5'h04;
			settle();
			pos();
			chk("oc latch", 8'h01 << (i / 2), oc_l);
			chk("tripped bridge", 1'b0, i < 2 ? br_a : br_b);
			chk("other bridge", 1'b1, i < 2 ? br_b : br_a);
			drv_off = 1'b1;
			settle();
			drv_off = 1'b0;
			settle();
			chk("oc latch", 8'h00, oc_l);
			brg(1'b1);
		end
		$display("test overcurrent done");
		mv(1'b1, 2'h3);
		ot = 1'b1;
		settle();
		idx = 5'h04;
		chk("overtemp", 1'b1, ot_s);
		brg(1'b0);
		i_mic_motion_model.step(1'b1, 2'h3);
		pos();
		ot = 1'b0;
		settle();
		chk("overtemp", 1'b0, ot_s);
		brg(1'b1);
		mv(1'b1, 2'h3);
		uv = 1'b1;
		settle();
		idx = 5'h04;
		pos();
		chk("lockout", 1'b1, uv_l);
		chk("pump", 1'b0, pump);
		brg(1'b0);
		uv = 1'b0;
		settle();
		chk("lockout", 1'b0, uv_l);
		brg(1'b1);
		mv(1'b0, 2'h2);
		$display("test faults done");
		complete_run();
	end
endmodule

// ---- hdl/mic_cur_if.sv ----
`timescale 1ns/10ps
interface mic_cur_if;
	logic [4:0] index;
	logic [7:0] a_cur;
	logic [7:0] b_cur;
	modport lookup (input index, output a_cur, output b_cur);
	modport user (output index, input a_cur, input b_cur);
endinterface

// ---- hdl/mic_cur_table.sv ----
`timescale 1ns/10ps
module mic_cur_table (
	// Table lookup
	mic_cur_if.lookup tbl
);
	function automatic logic [7:0] mic_neg(input logic [7:0] v);
		return 8'h00 - v;
	endfunction

	// Cosine or sine magnitude at one position of a quadrant
	function automatic logic [7:0] mic_mag(input logic [2:0] pos, input logic sine);
		logic [3:0] far;
		far = 4'h8 - {1'b0, pos};
		if (!sine) begin
			return mic_pkg::COS_MAG[pos];
		end
		if (pos == 3'h0) begin
			return 8'h00;
		end
		return mic_pkg::COS_MAG[far[2:0]];
	endfunction

	logic [2:0] pos;
	logic [7:0] cos_m;
	logic [7:0] sin_m;

	assign pos   = tbl.index[2:0];
	assign cos_m = mic_mag(pos, 1'b0);
	assign sin_m = mic_mag(pos, 1'b1);

	// [R16] First quadrant targets
	// [R17] Other quadrants by sign and swap
	always_comb begin
		case (tbl.index[4:3])
			2'h0: begin
				tbl.a_cur = cos_m;
				tbl.b_cur = sin_m;
			end
			2'h1: begin
				tbl.a_cur = mic_neg(sin_m);
				tbl.b_cur = cos_m;
			end
			2'h2: begin
				tbl.a_cur = mic_neg(cos_m);
				tbl.b_cur = mic_neg(sin_m);
			end
			default: begin
				tbl.a_cur = sin_m;
				tbl.b_cur = mic_neg(cos_m);
			end
		endcase
	end
endmodule

// ---- hdl/mic_indexer_ctrl.sv ----
// Function
// [R1] Overcurrent shuts that bridge off until drive-off pulses high then low, or power cycle.
// [R2] Overcurrent trips on current in either direction through a bridge.
// [R3] Overcurrent detector is its own input, apart from chopping comparator path.
// [R4] Overcurrent event also returns the indexer to home.
// [R5] Overtemperature shuts drivers off, homes indexer, resumes by itself when clear.
// [R6] Supply lockout disables everything and homes indexer until supply recovers.
// [R7] Clear input low holds indexer at home and both bridges off.
// [R8] Advance pulses are ignored while the clear input is low.
// [R9] Drive-off low enables both bridges; high disables them to high impedance.
// [R10] With drive-off high the indexer still follows advance and direction.
// [R11] Low-power request stops bridges, charge pump and internal clocks.
// [R12] In low-power state every input is ignored until the request ends; the code still lets supply-low move it to lockout and home.
// [R13] Two select pins choose full, half, quarter or eighth step.
// [R14] Each advance rising edge moves one table state, forward when direction high.
// [R15] Home is the 45 degree entry; home flag low there, high elsewhere.
// [R16] States 1 to 8 give the first quadrant current targets.
// [R17] States 9 to 32 follow cosine and sine; wrap in both directions.
// [R18] Coarse resolutions stride 8, 4 or 2 table entries.
`timescale 1ns/10ps
module mic_indexer_ctrl (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_n_i,
	// Motion controller pins
	input  wire logic       advance_pulse_i,
	input  wire logic       rotation_direction_i,
	input  wire logic       resolution_sel_hi_i,
	input  wire logic       resolution_sel_lo_i,
	input  wire logic       output_drive_off_i,
	input  wire logic       indexer_clear_n_i,
	input  wire logic       low_power_request_n_i,
	// Fault detectors: [0] A source, [1] A sink, [2] B source, [3] B sink
	input  wire logic [3:0] overcurrent_trip_i,
	input  wire logic       overtemp_flag_i,
	input  wire logic       motor_supply_low_i,
	// Current targets and bridge control
	output logic [7:0]      winding_a_target_o,
	output logic [7:0]      winding_b_target_o,
	output logic            bridge_a_enable_o,
	output logic            bridge_b_enable_o,
	output logic            charge_pump_run_o,
	output logic            internal_clock_run_o,
	// Status
	output logic            home_flag_n_o,
	output logic [1:0]      overcurrent_latch_o,
	output logic            overtemp_shutdown_o,
	output logic            supply_lockout_o
);
	logic [mic_pkg::SYNC_W-1:0] sync1_reg;
	logic [mic_pkg::SYNC_W-1:0] sync2_reg;
	logic [mic_pkg::SYNC_W-1:0] raw_in;
	logic                       step_prev_reg;
	logic                       off_prev_reg;
	logic [4:0]                 index_reg;
	logic [4:0]                 index_next;
	logic [1:0]                 latch_reg;
	logic [1:0]                 latch_next;
	logic [1:0]                 oc_hit;
	mic_pkg::mic_pwr_t          pwr_state_reg;
	mic_pkg::mic_pwr_t          pwr_next;
	logic                       run;
	logic                       step_s;
	logic                       dir_s;
	logic [1:0]                 sel_s;
	logic                       off_s;
	logic                       clr_n_s;
	logic                       lp_n_s;
	logic                       ot_s;
	logic                       uv_s;
	logic [3:0]                 oc_s;
	logic                       step_rise;
	logic                       step_take;
	logic                       off_fall;
	logic                       oc_new;
	logic                       bridge_ok;
	mic_cur_if                  cur_if ();

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// [R13] Select pins decode
	// [R18] Stride per resolution
	function automatic logic [4:0] mic_stride(input logic [1:0] sel);
		case (sel)
			mic_pkg::SEL_FULL:    return mic_pkg::STRIDE_FULL;
			mic_pkg::SEL_HALF:    return mic_pkg::STRIDE_HALF;
			mic_pkg::SEL_QUARTER: return mic_pkg::STRIDE_QUARTER;
			default:              return mic_pkg::STRIDE_EIGHTH;
		endcase
	endfunction

	assign raw_in = {overcurrent_trip_i, motor_supply_low_i, overtemp_flag_i, low_power_request_n_i,
		indexer_clear_n_i, output_drive_off_i, resolution_sel_hi_i, resolution_sel_lo_i,
		rotation_direction_i, advance_pulse_i};

	// Two-stage synchroniser for every pin
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_reg <= mic_pkg::SYNC_RST;
			sync2_reg <= mic_pkg::SYNC_RST;
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
		end
	end

	assign step_s  = sync2_reg[mic_pkg::SY_STEP];
	assign dir_s   = sync2_reg[mic_pkg::SY_DIR];
	assign sel_s   = {sync2_reg[mic_pkg::SY_SEL_HI], sync2_reg[mic_pkg::SY_SEL_LO]};
	assign off_s   = sync2_reg[mic_pkg::SY_OFF];
	assign clr_n_s = sync2_reg[mic_pkg::SY_CLR_N];
	assign lp_n_s  = sync2_reg[mic_pkg::SY_LP_N];
	assign ot_s    = sync2_reg[mic_pkg::SY_OT];
	assign uv_s    = sync2_reg[mic_pkg::SY_UV];
	assign oc_s    = sync2_reg[mic_pkg::SY_OC_LO +: 4];

	// Edge history tracks the pins even while asleep, so no stale edge fires on wake
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			step_prev_reg <= 1'b0;
			off_prev_reg  <= 1'b0;
		end else begin
			step_prev_reg <= step_s;
			off_prev_reg  <= off_s;
		end
	end

	assign step_rise = step_s & ~step_prev_reg;
	assign off_fall  = off_prev_reg & ~off_s;

	// [R6] Lockout takes precedence over low power
	always_comb begin
		if (uv_s) begin
			pwr_next = mic_pkg::MIC_PWR_LOCK;
		end else if (!lp_n_s) begin
			pwr_next = mic_pkg::MIC_PWR_SLEEP;
		end else begin
			pwr_next = mic_pkg::MIC_PWR_RUN;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwr_state_reg <= mic_pkg::MIC_PWR_LOCK;
		end else begin
			pwr_state_reg <= pwr_next;
		end
	end

	assign run = (pwr_state_reg == mic_pkg::MIC_PWR_RUN);

	// [R2] Either current direction trips the bridge
	// [R3] Dedicated trip inputs, not the chopping comparator
	assign oc_hit = {run & (oc_s[2] | oc_s[3]), run & (oc_s[0] | oc_s[1])};
	assign oc_new = |(oc_hit & ~latch_reg);

	// [R1] Latch holds until drive-off falls; a trip in that cycle wins
	assign latch_next = oc_hit | (latch_reg & ~{2{run & off_fall}});

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			latch_reg <= 2'b00;
		end else begin
			latch_reg <= latch_next;
		end
	end

	// [R8] Advance ignored under clear, overtemperature, a new overcurrent trip, lockout and low power
	// [R10] Drive-off does not gate stepping
	assign step_take = step_rise & run & clr_n_s & ~ot_s & ~oc_new;

	always_comb begin
		index_next = index_reg;
		case (pwr_state_reg)
			mic_pkg::MIC_PWR_LOCK: begin
				// [R6] Lockout homes the indexer
				index_next = mic_pkg::HOME_IDX;
			end
			mic_pkg::MIC_PWR_SLEEP: begin
				// [R12] Frozen while asleep
				index_next = index_reg;
			end
			default: begin
				// [R7] Clear holds home
				// [R5] Overtemperature homes
				// [R4] Overcurrent event homes
				if (!clr_n_s || ot_s || oc_new) begin
					index_next = mic_pkg::HOME_IDX;
				// [R14] Direction picks forward or reverse
				// [R17] Modulo 32 wraps both ways
				end else if (step_take && dir_s) begin
					index_next = index_reg + mic_stride(sel_s);
				end else if (step_take) begin
					index_next = index_reg - mic_stride(sel_s);
				end
			end
		endcase
	end

	// [R15] Home on reset and power-up
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			index_reg <= mic_pkg::HOME_IDX;
		end else begin
			index_reg <= index_next;
		end
	end

	assign cur_if.index = index_next;

	mic_cur_table u_table (
		.tbl (cur_if.lookup)
	);

	// Targets and home flag registered from the next index, so they line up with it
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			winding_a_target_o <= mic_pkg::CUR_RST;
			winding_b_target_o <= mic_pkg::CUR_RST;
			home_flag_n_o      <= 1'b0;
		end else begin
			winding_a_target_o <= cur_if.a_cur;
			winding_b_target_o <= cur_if.b_cur;
			// [R15] Flag low only at home
			home_flag_n_o      <= (index_next != mic_pkg::HOME_IDX);
		end
	end

	// [R9] Drive-off gates the bridges
	// [R7] Clear keeps them off
	// [R5] Overtemperature keeps them off
	assign bridge_ok = run & clr_n_s & ~off_s & ~ot_s;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bridge_a_enable_o <= 1'b0;
			bridge_b_enable_o <= 1'b0;
		end else begin
			// [R1] Tripped bridge stays off
			bridge_a_enable_o <= bridge_ok & ~latch_next[0];
			bridge_b_enable_o <= bridge_ok & ~latch_next[1];
		end
	end

	// [R11] Pump and clocks stop in low power
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			charge_pump_run_o    <= 1'b0;
			internal_clock_run_o <= 1'b0;
		end else begin
			charge_pump_run_o    <= (pwr_next == mic_pkg::MIC_PWR_RUN);
			internal_clock_run_o <= (pwr_next == mic_pkg::MIC_PWR_RUN);
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			overtemp_shutdown_o <= mic_pkg::FLAG_RST;
			supply_lockout_o    <= 1'b1;
		end else begin
			overtemp_shutdown_o <= ot_s & run;
			supply_lockout_o    <= (pwr_next == mic_pkg::MIC_PWR_LOCK);
		end
	end

	assign overcurrent_latch_o = latch_reg;

	clear_homes_a: assert property (run && !clr_n_s |=> index_reg == mic_pkg::HOME_IDX // [R7]
		&& !bridge_a_enable_o && !bridge_b_enable_o)
		else $error("clear did not home and disable");

	clear_ignores_step_a: assert property (run && !clr_n_s && step_rise // [R8]
		|=> index_reg == mic_pkg::HOME_IDX)
		else $error("advance taken under clear");

	oc_latch_hold_a: assert property (latch_reg[0] && !(run && off_fall) |=> latch_reg[0]) // [R1]
		else $error("overcurrent latch released early");

	oc_bridge_off_a: assert property (overcurrent_latch_o[1] |-> !bridge_b_enable_o) // [R1]
		else $error("bridge driven while latched");

	oc_both_dirs_a: assert property (run && (oc_s[2] || oc_s[3]) |=> latch_reg[1]) // [R2]
		else $error("overcurrent direction missed");

	oc_homes_a: assert property (run && oc_hit[0] && !latch_reg[0] // [R4]
		|=> index_reg == mic_pkg::HOME_IDX)
		else $error("overcurrent did not home");

	ot_shutdown_a: assert property (run && ot_s |=> index_reg == mic_pkg::HOME_IDX // [R5]
		&& !bridge_a_enable_o && overtemp_shutdown_o)
		else $error("overtemperature not handled");

	lockout_home_a: assert property (uv_s |=> !charge_pump_run_o && supply_lockout_o // [R6]
		##1 index_reg == mic_pkg::HOME_IDX)
		else $error("lockout not handled");

	drive_off_a: assert property (off_s |=> !bridge_a_enable_o && !bridge_b_enable_o) // [R9]
		else $error("bridges on with drive off");

	step_forward_a: assert property (step_take && dir_s && off_s // [R10]
		|=> index_reg == 5'($past(index_reg) + mic_stride($past(sel_s))))
		else $error("forward step wrong");

	step_reverse_a: assert property (step_take && !dir_s && sel_s == mic_pkg::SEL_FULL // [R18]
		|=> index_reg == 5'($past(index_reg) - mic_pkg::STRIDE_FULL))
		else $error("reverse full step wrong");

	sleep_freeze_a: assert property (pwr_state_reg == mic_pkg::MIC_PWR_SLEEP // [R12]
		|=> $stable(index_reg))
		else $error("indexer moved while asleep");

	sleep_stops_a: assert property (!lp_n_s |=> !charge_pump_run_o && !internal_clock_run_o) // [R11]
		else $error("pump or clock running while asleep");

	home_flag_a: assert property (home_flag_n_o == (index_reg != mic_pkg::HOME_IDX)) // [R15]
		else $error("home flag mismatch");

	wrap_a: assert property (step_take && dir_s && index_reg == 5'h1f // [R17]
		&& sel_s == mic_pkg::SEL_EIGHTH |=> index_reg == 5'h00)
		else $error("forward wrap wrong");

	cover_full_turn_c: cover property (step_take && sel_s == mic_pkg::SEL_EIGHTH ##1 index_reg == 5'h00);
	cover_oc_clear_c: cover property (latch_reg[0] ##1 off_s [*2] ##1 !off_s ##1 !latch_reg[0]);
	cover_sleep_wake_c: cover property (pwr_state_reg == mic_pkg::MIC_PWR_SLEEP ##1 run ##[1:20] step_take);
	cover_ot_resume_c: cover property (ot_s ##1 !ot_s ##[1:20] bridge_a_enable_o);
endmodule

// ---- hdl/mic_pkg.sv ----
package mic_pkg;
	// Indexer geometry
	localparam int         IDX_W        = 5;
	localparam int         CUR_W        = 8;
	localparam logic [4:0] HOME_IDX     = 5'h04;

	// Resolution select codes {hi, lo}
	localparam logic [1:0] SEL_FULL     = 2'h0;
	localparam logic [1:0] SEL_HALF     = 2'h1;
	localparam logic [1:0] SEL_QUARTER  = 2'h2;
	localparam logic [1:0] SEL_EIGHTH   = 2'h3;

	// Table stride per resolution
	localparam logic [4:0] STRIDE_FULL    = 5'h08;
	localparam logic [4:0] STRIDE_HALF    = 5'h04;
	localparam logic [4:0] STRIDE_QUARTER = 5'h02;
	localparam logic [4:0] STRIDE_EIGHTH  = 5'h01;

	// Positions in the synchroniser vector
	localparam int         SYNC_W       = 13;
	localparam int         SY_STEP      = 0;
	localparam int         SY_DIR       = 1;
	localparam int         SY_SEL_LO    = 2;
	localparam int         SY_SEL_HI    = 3;
	localparam int         SY_OFF       = 4;
	localparam int         SY_CLR_N     = 5;
	localparam int         SY_LP_N      = 6;
	localparam int         SY_OT        = 7;
	localparam int         SY_UV        = 8;
	localparam int         SY_OC_LO     = 9;

	// Reset values
	localparam logic [12:0] SYNC_RST    = 13'h0000;
	localparam logic [7:0]  CUR_RST     = 8'h47;
	localparam logic        FLAG_RST    = 1'b0;

	// Cosine magnitudes in percent for the eight positions of a quadrant
	localparam logic [7:0] COS_MAG [0:7] = '{8'h64, 8'h62, 8'h5c, 8'h53, 8'h47, 8'h38, 8'h26, 8'h14};

	typedef enum logic [1:0] {
		MIC_PWR_RUN   = 2'b00,
		MIC_PWR_SLEEP = 2'b01,
		MIC_PWR_LOCK  = 2'b10
	} mic_pwr_t;
endpackage
